// >>> osp_pkg.sv
// Package for the one-shot pulse timer: constants and carrier types.
`default_nettype none
package osp_pkg;
   // ---------------------------------------------------------------
   // Widths and encodings
   // ---------------------------------------------------------------
   localparam int CODE_W = 4;
   localparam int CNT_W  = 22;
   localparam int INV_BIT = 3;
   localparam int SEL_MSB = 2;
   // ---------------------------------------------------------------
   // Timing constants, in master-oscillator ticks, and the adopt counter width in bits
   // ---------------------------------------------------------------
   localparam int STARTUP_TICKS  = 500;
   localparam int ADOPT_SCALE    = 16;
   localparam int ADOPT_OFFSET   = 6;
   localparam int REARM_TICKS    = 2;
   localparam int ADOPT_W        = 10;
   // ---------------------------------------------------------------
   // Divide ratios, ascending with the low three code bits
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] RATIO [8] = '{
      22'h000001, 22'h000008, 22'h000040, 22'h000200,
      22'h001000, 22'h008000, 22'h040000, 22'h200000};

   typedef struct packed {
      logic rising_edge;   // 1: rising edge triggers, 0: falling
      logic retrigger;     // 1: retriggerable
   } osp_cfg_t;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_IDLE  = 2'b01,
      ST_PULSE = 2'b10,
      ST_REARM = 2'b11
   } osp_state_t;
endpackage : osp_pkg
`default_nettype wire

// >>> osp_code_filter.sv
// Divider select code filter: adopts a new code only after it holds stable.
`timescale 1ns/1ps
`default_nettype none
module osp_code_filter (
   input  wire logic                       clk,      // System clock
   input  wire logic                       rst_n,    // Sync reset, low
   input  wire logic                       tick,     // Master tick enable
   input  wire logic [osp_pkg::CODE_W-1:0] code_in,  // Synchronised code
   output logic      [osp_pkg::CODE_W-1:0] code_out, // Adopted code
   output logic                            valid     // Code determined
);
   import osp_pkg::*;

   logic [CODE_W-1:0]  cand_ff, nxt_cand;
   logic [CODE_W-1:0]  code_ff, nxt_code;
   logic [ADOPT_W-1:0] cnt_ff, nxt_cnt;
   logic               valid_ff, nxt_valid;
   logic [CODE_W-1:0]  diff;
   logic [ADOPT_W-1:0] need;

   // The wait scales with the jump size, so large jumps are trusted least.
   always_comb begin
      diff = (cand_ff > code_ff) ? cand_ff - code_ff : code_ff - cand_ff;
      need = ADOPT_W'(ADOPT_SCALE * (int'(diff) + ADOPT_OFFSET));
      nxt_cand  = cand_ff;
      nxt_code  = code_ff;
      nxt_cnt   = cnt_ff;
      nxt_valid = valid_ff;
      if (tick) begin
         if (code_in != cand_ff) begin
            nxt_cand = code_in;
            nxt_cnt  = '0;
         end else if (!valid_ff || cand_ff != code_ff) begin
            if (cnt_ff + 1'b1 >= need) begin
               nxt_code  = cand_ff;
               nxt_valid = 1'b1;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cand_ff  <= 4'h0;
         code_ff  <= 4'h0;
         cnt_ff   <= '0;
         valid_ff <= 1'b0;
      end else begin
         cand_ff  <= nxt_cand;
         code_ff  <= nxt_code;
         cnt_ff   <= nxt_cnt;
         valid_ff <= nxt_valid;
      end
   end

   assign code_out = code_ff;
   assign valid    = valid_ff;

   code_jump_a: assert property (@(posedge clk)
      disable iff (!rst_n)
      $changed(code_ff) && valid_ff |-> code_ff == $past(cand_ff))
      else $error("adopted code skipped to a non-candidate value");
endmodule : osp_code_filter
`default_nettype wire

// >>> osp_one_shot.sv
// Top of the one-shot pulse timer: trigger detect, start-up, duration count.
`timescale 1ns/1ps
`default_nettype none
module osp_one_shot (
   input  wire logic                       SYS_CLK,  // 40 MHz clock
   input  wire logic                       RST_N,    // Sync reset, low
   input  wire logic                       MASTER_TICK, // Master osc tick
   input  wire logic                       TRIGGER_INPUT, // Trigger pin
   input  wire logic [osp_pkg::CODE_W-1:0] DIVIDER_SELECT_CODE, // Code pin
   input  wire osp_pkg::osp_cfg_t          CFG,      // Edge/retrigger
   output logic                            PULSE_OUT, // Pulse output
   output logic                            READY,    // Start-up done
   output logic [osp_pkg::CODE_W-1:0]      ACTIVE_CODE // Adopted code
);
   import osp_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic              trg_s1_ff, trg_s2_ff, trg_d_ff;
   logic              tick_s1_ff, tick_s2_ff, tick_d_ff;
   logic [CODE_W-1:0] code_s1_ff, code_s2_ff;
   osp_cfg_t          cfg_s1_ff, cfg_s2_ff;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         trg_s1_ff  <= 1'b0;
         trg_s2_ff  <= 1'b0;
         trg_d_ff   <= 1'b0;
         tick_s1_ff <= 1'b0;
         tick_s2_ff <= 1'b0;
         tick_d_ff  <= 1'b0;
         code_s1_ff <= 4'h0;
         code_s2_ff <= 4'h0;
         cfg_s1_ff  <= '0;
         cfg_s2_ff  <= '0;
      end else begin
         trg_s1_ff  <= TRIGGER_INPUT;
         trg_s2_ff  <= trg_s1_ff;
         trg_d_ff   <= trg_s2_ff;
         tick_s1_ff <= MASTER_TICK;
         tick_s2_ff <= tick_s1_ff;
         tick_d_ff  <= tick_s2_ff;
         code_s1_ff <= DIVIDER_SELECT_CODE;
         code_s2_ff <= code_s1_ff;
         cfg_s1_ff  <= CFG;
         cfg_s2_ff  <= cfg_s1_ff;
      end
   end

   // A master-oscillator period becomes a one-cycle enable on its rising edge.
   logic tick;
   logic edge_seen;
   assign tick = tick_s2_ff & ~tick_d_ff;
   assign edge_seen = cfg_s2_ff.rising_edge ?
                      (trg_s2_ff & ~trg_d_ff) : (~trg_s2_ff & trg_d_ff);

   // ---------------------------------------------------------------
   // Code filter
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] code;
   logic              code_ok;

   osp_code_filter u_filter (
      .clk      (SYS_CLK),
      .rst_n    (RST_N),
      .tick     (tick),
      .code_in  (code_s2_ff),
      .code_out (code),
      .valid    (code_ok)
   );

   logic              inv;
   logic [CNT_W-1:0]  ratio;
   // Upper codes mirror the lower ones, so fold the low bits on inversion.
   assign inv   = code[INV_BIT];
   assign ratio = RATIO[inv ? ~code[SEL_MSB:0] : code[SEL_MSB:0]];

   // ---------------------------------------------------------------
   // Sequencer and duration counter
   // ---------------------------------------------------------------
   osp_state_t       st_ff, nxt_st;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic             out_ff, nxt_out;

   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_out = out_ff;
      unique case (st_ff)
         ST_START: begin
            nxt_out = 1'b0;
            if (tick && cnt_ff < CNT_W'(STARTUP_TICKS)) begin
               nxt_cnt = cnt_ff + 1'b1;
            end
            if (cnt_ff >= CNT_W'(STARTUP_TICKS) && code_ok) begin
               nxt_st  = ST_IDLE;
               nxt_out = inv;
               nxt_cnt = '0;
            end
         end
         ST_IDLE: begin
            nxt_out = inv;
            if (edge_seen) begin
               nxt_st  = ST_PULSE;
               nxt_out = ~inv;
               nxt_cnt = ratio;
            end
         end
         ST_PULSE: begin
            // Ratio is read live, so a code change to a ratio below the remaining count ends the pulse at the next tick.
            if (edge_seen && cfg_s2_ff.retrigger) begin
               nxt_cnt = ratio;
            end else if (tick) begin
               if (cnt_ff <= 22'h000001 || cnt_ff > ratio) begin
                  nxt_st  = ST_REARM;
                  nxt_out = inv;
                  nxt_cnt = CNT_W'(REARM_TICKS);
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            if (!(nxt_st == ST_REARM)) begin
               nxt_out = ~inv;
            end
         end
         ST_REARM: begin
            nxt_out = inv;
            if (cfg_s2_ff.retrigger && edge_seen) begin
               nxt_st  = ST_PULSE;
               nxt_out = ~inv;
               nxt_cnt = ratio;
            end else if (tick) begin
               if (cnt_ff <= 22'h000001) begin
                  nxt_st = ST_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_ff  <= ST_START;
         cnt_ff <= '0;
         out_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         out_ff <= nxt_out;
      end
   end

   assign PULSE_OUT   = out_ff;
   assign READY       = (st_ff != ST_START);
   assign ACTIVE_CODE = code;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   start_low_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N) st_ff == ST_START |-> !out_ff)
      else $error("output not low during start-up");
   // The level register trails a newly adopted code by one clock.
   idle_level_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N) st_ff == ST_IDLE |-> out_ff == $past(inv))
      else $error("idle level does not follow invert bit");
   edge_start_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N) st_ff == ST_IDLE && edge_seen
      |=> st_ff == ST_PULSE && out_ff != $past(inv))
      else $error("trigger edge did not start a pulse");
   no_early_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N) st_ff == ST_START |=> st_ff != ST_PULSE)
      else $error("pulse before start-up end");
   start_len_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N)
      st_ff == ST_START && $past(st_ff) == ST_START ##1 st_ff == ST_IDLE
      |-> $past(cnt_ff) >= CNT_W'(STARTUP_TICKS))
      else $error("start-up ended before 500 ticks");
   hold_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N)
      st_ff == ST_PULSE && !tick && !edge_seen |=> st_ff == ST_PULSE)
      else $error("pulse ended without a tick");
   retrig_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N)
      st_ff == ST_PULSE && edge_seen && cfg_s2_ff.retrigger
      |=> cnt_ff == $past(ratio))
      else $error("retrigger did not reload count");
   noretrig_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N)
      st_ff == ST_REARM && !cfg_s2_ff.retrigger |=> st_ff != ST_PULSE)
      else $error("edge accepted during rearm");
   ratio_map_a: assert property (@(posedge SYS_CLK)
      disable iff (!RST_N)
      code == 4'h0 || code == 4'hF |-> ratio == 22'h000001)
      else $error("end codes do not select ratio one");
   startup_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_ff == ST_START ##1 st_ff == ST_IDLE);
   pulse_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_ff == ST_PULSE ##1 st_ff == ST_REARM);
   retrig_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_ff == ST_PULSE && edge_seen && cfg_s2_ff.retrigger);
   inverted_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_ff == ST_PULSE && inv);
endmodule : osp_one_shot
`default_nettype wire

// >>> osp_far_model.sv
// Far-side model: master oscillator ticks and the trigger source.
`timescale 1ns/1ps
`default_nettype none
module osp_far_model (
   input  wire logic clk,  // Bench clock
   output logic      tick, // Master oscillator
   output logic      trigger_input // Trigger pin
);
   logic run_en    = 1'b1;
   int   phase     = 0;
   int   tick_cnt  = 0;
   int   edge_tick = 0;

   initial tick = 1'b0;
   initial trigger_input = 1'b0;

   // A stalled oscillator freezes at whatever level it had, as a
   // starved one would; the count of rising edges stops with it.
   always @(negedge clk) begin
      if (run_en) begin
         phase = (phase == 2) ? 0 : phase + 1;
         if (phase == 0) begin
            tick = ~tick;
            if (tick) tick_cnt++;
         end
      end
   end

   // The idle level is set first, so a change of edge mode never
   // produces a stray active edge.
   task automatic fire(input logic rise);
      @(negedge clk);
      trigger_input = ~rise;
      repeat (4) @(negedge clk);
      trigger_input = rise;
      edge_tick = tick_cnt;
      repeat (4) @(negedge clk);
      trigger_input = ~rise;
      repeat (4) @(negedge clk);
   endtask : fire
endmodule : osp_far_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the one-shot pulse timer.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import osp_pkg::*;
   logic              sys_clk  = 1'b0;
   logic              rst_n    = 1'b0;
   logic [CODE_W-1:0] code     = 4'hE;
   osp_cfg_t          cfg      = '{rising_edge: 1'b1, retrigger: 1'b0};
   logic              pulse;
   logic              ready;
   logic [CODE_W-1:0] act_code;
   wire  logic        tick;
   wire  logic        trigger_input;
   logic [31:0]       seed     = 32'hADC793D1;
   logic              mon_en   = 1'b0;
   logic              in_p     = 1'b0;
   int                errors   = 0;
   int                samples_checked = 0;
   int                cycles   = 0;
   int                t0       = 0;
   int                exp_q[$];

   always #12.5 sys_clk = ~sys_clk;

   osp_far_model far (.clk(sys_clk), .tick(tick),
      .trigger_input(trigger_input));
   osp_one_shot uut (.SYS_CLK(sys_clk), .RST_N(rst_n),
      .MASTER_TICK(tick), .TRIGGER_INPUT(trigger_input),
      .DIVIDER_SELECT_CODE(code), .CFG(cfg), .PULSE_OUT(pulse),
      .READY(ready), .ACTIVE_CODE(act_code));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int ratio_of(input logic [3:0] c);
      return 1 << (3 * (c[3] ? 7 - c[2:0] : c[2:0]));
   endfunction : ratio_of

   // Tick counts carry a small tolerance: the first tick of a pulse
   // may be partial and the tick input crosses a synchroniser.
   task automatic cmp_cnt(input int got, input int exp, input int tol);
      samples_checked++;
      if (got < exp - tol || got > exp + tol) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_cnt

   task automatic cmp_bits(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bits

   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task automatic wait_ticks(input int k);
      int s = far.tick_cnt;
      while (far.tick_cnt < s + k) @(posedge sys_clk);
   endtask : wait_ticks

   task automatic wait_idle;
      int n = 0;
      while ((in_p || exp_q.size() != 0) && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      wait_ticks(3);
   endtask : wait_idle

   task automatic change_code(input logic [3:0] nc);
      logic [3:0] old;
      int         d;
      int         s;
      old = act_code;
      mon_en = 1'b0;
      seed = lfsr(seed);
      @(negedge sys_clk);
      code = nc ^ {seed[3:1], 1'b1};
      wait_ticks(5);
      @(negedge sys_clk);
      code = nc;
      s = far.tick_cnt;
      d = (nc > old) ? int'(nc - old) : int'(old - nc);
      while (act_code !== nc && far.tick_cnt < s + 400) begin
         @(posedge sys_clk);
         if (act_code !== old && act_code !== nc)
            cmp_bits(act_code, nc);
      end
      cmp_cnt(far.tick_cnt - s, 16 * (d + 6), 2);
      cmp_bits(act_code, nc);
      repeat (3) @(negedge sys_clk);
      mon_en = 1'b1;
   endtask : change_code

   // ---------------------------------------------------------------
   // Watchers
   // ---------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         finish_test();
      end
   end

   always @(posedge sys_clk) begin
      if (rst_n && ready !== 1'b1) cmp_bits({3'h0, pulse}, 4'h0);
      else if (mon_en && pulse !== act_code[INV_BIT] && !in_p) begin
         in_p = 1'b1;
         t0 = far.tick_cnt;
      end else if (mon_en && pulse === act_code[INV_BIT] && in_p) begin
         in_p = 1'b0;
         if (exp_q.size() == 0) cmp_cnt(far.tick_cnt - t0, 0, 0);
         else cmp_cnt(far.tick_cnt - t0, exp_q.pop_front(), 2);
      end
   end

   initial begin
      int s;
      int e1;
      logic [3:0] codes [4] = '{4'h1, 4'h2, 4'hF, 4'h0};
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      s = far.tick_cnt;
      far.fire(1'b1);
      while (ready !== 1'b1 && cycles < 20000) @(posedge sys_clk);
      cmp_cnt(far.tick_cnt - s, 500, 3);
      repeat (3) @(negedge sys_clk);
      cmp_bits(act_code, code);
      cmp_bits({3'h0, pulse}, {3'h0, code[INV_BIT]});
      mon_en = 1'b1;
      $display("startup done");
      for (int m = 0; m < 4; m++) begin
         @(negedge sys_clk);
         cfg = '{rising_edge: m[0], retrigger: m[1]};
         repeat (4) @(negedge sys_clk);
         if (!cfg.retrigger) exp_q.push_back(ratio_of(code));
         far.fire(cfg.rising_edge);
         e1 = far.edge_tick;
         wait_ticks(2);
         far.fire(cfg.rising_edge);
         if (cfg.retrigger) exp_q.push_back(far.edge_tick - e1 + 8);
         wait_idle();
         $display("mode %0d done", m);
      end
      exp_q.push_back(ratio_of(code));
      far.run_en = 1'b0;
      far.fire(cfg.rising_edge);
      repeat (200) @(negedge sys_clk);
      cmp_bits({3'h0, pulse}, {3'h0, ~code[INV_BIT]});
      far.run_en = 1'b1;
      wait_idle();
      $display("stall done");
      // Codes are kept to short ratios so the run stays brief.
      foreach (codes[i]) begin
         change_code(codes[i]);
         seed = lfsr(seed);
         repeat (seed[2:0]) @(negedge sys_clk);
         exp_q.push_back(ratio_of(codes[i]));
         far.fire(cfg.rising_edge);
         wait_idle();
         $display("code %h done", codes[i]);
      end
      finish_test();
   end
endmodule : tb
`default_nettype wire
